// ==== include/prdec_pkg.sv ====
// constants and types for the peripheral register transfer decoder
// assumes one core clock and a synchronous active-high reset
package prdec_pkg;

    // instruction word width and data widths
    localparam int OPCODE_W = 10;
    localparam int NIBBLE_W = 4;
    localparam int CMP_W    = 8;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 8;

    // opcodes of the decoded transfer group
    localparam logic [9:0] OP_LOAD_CMP   = 10'h239;
    localparam logic [9:0] OP_COPY_IRQ   = 10'h253;
    localparam logic [9:0] OP_COPY_SER   = 10'h262;
    localparam logic [9:0] OP_COPY_WAKE0 = 10'h256;

    // register offsets on the plain register port
    localparam logic [3:0] OFS_MODE  = 4'h0;
    localparam logic [3:0] OFS_IRQ   = 4'h1;
    localparam logic [3:0] OFS_SER   = 4'h2;
    localparam logic [3:0] OFS_WAKE0 = 4'h3;
    localparam logic [3:0] OFS_ACC   = 4'h4;
    localparam logic [3:0] OFS_BREG  = 4'h5;
    localparam logic [3:0] OFS_CMP   = 4'h6;
    localparam logic [3:0] OFS_CARRY = 4'h7;
    localparam logic [3:0] OFS_LAST  = 4'h8;

    // field positions and reset values
    localparam int MODE_BIT  = 0;
    localparam int CARRY_BIT = 0;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [7:0] RST_CMP    = 8'h00;
    localparam logic       RST_BIT    = 1'b0;

    // what the decoder found in the current instruction word
    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_LOAD_NOP,
        KIND_LOAD_CMP,
        KIND_COPY_IRQ,
        KIND_COPY_SER,
        KIND_COPY_WAKE0
    } prdec_kind_t;

endpackage

// ==== include/prdec_exec_if.sv ====
// carrier between the execute core and the opcode decoder
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface prdec_exec_if;
    logic [9:0]            opcode;
    logic                  valid;
    logic                  mode;
    prdec_pkg::prdec_kind_t kind;

    modport decoder (input opcode, input valid, input mode, output kind);
    modport core    (output opcode, output valid, output mode, input kind);
endinterface

// ==== core/prdec_decoder.sv ====
// opcode decoder for the transfer group, purely combinational
// assumes the opcode is stable for the cycle in which valid is high
`timescale 1ns/1ps
module prdec_decoder (
    prdec_exec_if.decoder dec
);

    // map the word to an instruction kind; unknown words do nothing
    always_comb
    begin
        dec.kind = prdec_pkg::KIND_NONE;
        if (dec.valid)
        begin
            unique case (dec.opcode)
                prdec_pkg::OP_LOAD_CMP:
                    dec.kind = dec.mode ? prdec_pkg::KIND_LOAD_CMP
                                        : prdec_pkg::KIND_LOAD_NOP;
                prdec_pkg::OP_COPY_IRQ:
                    dec.kind = prdec_pkg::KIND_COPY_IRQ;
                prdec_pkg::OP_COPY_SER:
                    dec.kind = prdec_pkg::KIND_COPY_SER;
                prdec_pkg::OP_COPY_WAKE0:
                    dec.kind = prdec_pkg::KIND_COPY_WAKE0;
                default:
                    dec.kind = prdec_pkg::KIND_NONE;
            endcase
        end
    end

endmodule

// ==== core/prdec_top.sv ====
// execute core for the peripheral register transfer group
// assumes instructions arrive one word per cycle, synchronous to ref_clk_in
// Notes on behaviour
// - opcode 10'h239 loads the comparator in one cycle, no carry change.
// - in comparator mode the load puts B in bits 7..4 and A in bits 3..0.
// - in conversion mode the load opcode acts as a no-operation.
// - opcode 10'h253 copies the interrupt control register into A.
// - an instruction copies the serial control register into A.
// - opcode 10'h256 copies wakeup control register 0 into A, carry kept.
`timescale 1ns/1ps
module prdec_top (
    input  wire logic       ref_clk_in,
    input  wire logic       reset_in,
    input  wire logic [9:0] opcode_in,
    input  wire logic       opcode_valid_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    output logic            done_out,
    output logic            skip_out,
    output logic      [3:0] acc_out,
    output logic      [7:0] cmp_out,
    output logic            carry_out
);

    typedef struct packed {
        logic [3:0]             acc;
        logic [3:0]             breg;
        logic [7:0]             cmp;
        logic                   mode;
        logic [3:0]             irq;
        logic [3:0]             ser;
        logic [3:0]             wake0;
        logic                   carry;
        logic [7:0]             rdata;
        logic                   done;
        prdec_pkg::prdec_kind_t last;
    } prdec_state_t;

    prdec_state_t   st;
    prdec_state_t   next_st;
    prdec_exec_if   ex ();

    assign ex.opcode = opcode_in;
    assign ex.valid  = opcode_valid_in;
    assign ex.mode   = st.mode;

    prdec_decoder prdec_decoder_inst (
        .dec (ex.decoder)
    );

    // read mux; unmapped offsets answer zero
    function automatic logic [7:0] prdec_read(input prdec_state_t s,
                                              input logic [3:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            prdec_pkg::OFS_MODE:  v = {7'h00, s.mode};
            prdec_pkg::OFS_IRQ:   v = {4'h0, s.irq};
            prdec_pkg::OFS_SER:   v = {4'h0, s.ser};
            prdec_pkg::OFS_WAKE0: v = {4'h0, s.wake0};
            prdec_pkg::OFS_ACC:   v = {4'h0, s.acc};
            prdec_pkg::OFS_BREG:  v = {4'h0, s.breg};
            prdec_pkg::OFS_CMP:   v = s.cmp;
            prdec_pkg::OFS_CARRY: v = {7'h00, s.carry};
            prdec_pkg::OFS_LAST:  v = {5'h00, s.last};
            default:              v = 8'h00;
        endcase
        return v;
    endfunction

    // bus writes first, then the instruction; the instruction wins on A
    // and the comparator because the core must not lose a retired result
    always_comb
    begin
        next_st       = st;
        next_st.rdata = rd_in ? prdec_read(st, addr_in) : 8'h00;
        next_st.done  = 1'b0;
        if (wr_in)
        begin
            unique case (addr_in)
                prdec_pkg::OFS_MODE:
                    next_st.mode = wdata_in[prdec_pkg::MODE_BIT];
                prdec_pkg::OFS_IRQ:   next_st.irq   = wdata_in[3:0];
                prdec_pkg::OFS_SER:   next_st.ser   = wdata_in[3:0];
                prdec_pkg::OFS_WAKE0: next_st.wake0 = wdata_in[3:0];
                prdec_pkg::OFS_ACC:   next_st.acc   = wdata_in[3:0];
                prdec_pkg::OFS_BREG:  next_st.breg  = wdata_in[3:0];
                prdec_pkg::OFS_CMP:   next_st.cmp   = wdata_in;
                prdec_pkg::OFS_CARRY:
                    next_st.carry = wdata_in[prdec_pkg::CARRY_BIT];
                default:              next_st.mode  = st.mode;
            endcase
        end
        if (ex.kind != prdec_pkg::KIND_NONE)
        begin
            next_st.done = 1'b1;                 // one word, one cycle
            next_st.last = ex.kind;
        end
        // carry and skip are never touched by this group
        unique case (ex.kind)
            prdec_pkg::KIND_LOAD_CMP:
                next_st.cmp = {st.breg, st.acc};
            prdec_pkg::KIND_COPY_IRQ:
                next_st.acc = st.irq;
            prdec_pkg::KIND_COPY_SER:
                next_st.acc = st.ser;
            prdec_pkg::KIND_COPY_WAKE0:
                next_st.acc = st.wake0;
            default:
                next_st.acc = next_st.acc;           // no-operation
        endcase
    end

    // state register with synchronous reset
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            st       <= '0;
            st.acc   <= prdec_pkg::RST_NIBBLE;
            st.breg  <= prdec_pkg::RST_NIBBLE;
            st.cmp   <= prdec_pkg::RST_CMP;
            st.mode  <= prdec_pkg::RST_BIT;
            st.carry <= prdec_pkg::RST_BIT;
            st.last  <= prdec_pkg::KIND_NONE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata_out = st.rdata;
    assign done_out  = st.done;
    assign skip_out  = 1'b0;         // this group never skips
    assign acc_out   = st.acc;
    assign cmp_out   = st.cmp;
    assign carry_out = st.carry;

    // checks on the executed instructions
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    logic load_go;
    logic quiet;
    assign load_go = opcode_valid_in && opcode_in == prdec_pkg::OP_LOAD_CMP;
    assign quiet   = !wr_in;

    property p_load_one_cycle;
        load_go && quiet |=> done_out && carry_out == $past(carry_out)
                             && !skip_out;
    endproperty
    a_load_one_cycle: assert property (p_load_one_cycle)
        else $error("load did not retire in one cycle or moved carry");

    property p_load_cmp;
        load_go && st.mode && quiet |=> cmp_out == {$past(st.breg),
                                                    $past(acc_out)};
    endproperty
    a_load_cmp: assert property (p_load_cmp)
        else $error("comparator load took wrong nibbles");

    property p_load_nop;
        load_go && !st.mode && quiet |=> $stable(cmp_out) && $stable(acc_out)
            && st.last == prdec_pkg::KIND_LOAD_NOP;
    endproperty
    a_load_nop: assert property (p_load_nop)
        else $error("load in conversion mode changed state");

    property p_copy_irq;
        opcode_valid_in && opcode_in == prdec_pkg::OP_COPY_IRQ
            |=> acc_out == $past(st.irq) && done_out;
    endproperty
    a_copy_irq: assert property (p_copy_irq)
        else $error("irq control copy wrong");

    property p_copy_ser;
        opcode_valid_in && opcode_in == prdec_pkg::OP_COPY_SER
            |=> acc_out == $past(st.ser) && done_out;
    endproperty
    a_copy_ser: assert property (p_copy_ser)
        else $error("serial control copy wrong");

    property p_copy_wake0;
        opcode_valid_in && opcode_in == prdec_pkg::OP_COPY_WAKE0 && quiet
            |=> acc_out == $past(st.wake0) && $stable(carry_out);
    endproperty
    a_copy_wake0: assert property (p_copy_wake0)
        else $error("wakeup control copy wrong or carry moved");

    property p_copy_keeps;
        opcode_valid_in && quiet && (opcode_in == prdec_pkg::OP_COPY_IRQ
            || opcode_in == prdec_pkg::OP_COPY_SER
            || opcode_in == prdec_pkg::OP_COPY_WAKE0)
            |=> $stable(st.irq) && $stable(st.ser) && $stable(st.wake0)
                && $stable(cmp_out) && $stable(st.breg)
                && $stable(carry_out) && $stable(st.mode)
            ##1 (!done_out || $past(opcode_valid_in));
    endproperty
    a_copy_keeps: assert property (p_copy_keeps)
        else $error("copy disturbed other state");

    // read data stand for one cycle only, otherwise the port reads zero
    property p_idle_read;
        !rd_in |=> rdata_out == 8'h00;
    endproperty
    a_idle_read: assert property (p_idle_read)
        else $error("read data held past its cycle");

    // no word, no retirement: done must never pulse on its own
    property p_no_false_done;
        !opcode_valid_in |=> !done_out;
    endproperty
    a_no_false_done: assert property (p_no_false_done)
        else $error("done pulsed without an instruction");

    c_load_cmp: cover property (load_go && st.mode ##1 done_out);
    c_load_nop: cover property (load_go && !st.mode ##1 done_out);
    c_back2back: cover property (opcode_valid_in ##1 opcode_valid_in
                                 ##1 done_out);
    c_read: cover property (rd_in ##1 rdata_out != 8'h00);

endmodule

// ==== testbench/prdec_top_test.sv ====
// self-checking bench for the transfer decoder, bus and instruction ports
// assumes the offsets and opcodes of prdec_pkg and a 100 MHz core clock
`timescale 1ns/1ps
module prdec_top_test;
    typedef struct {string nm; logic [11:0] ex;} prdec_note_t;
    logic       ref_clk_in = 1'b0;
    logic       reset_in   = 1'b1;
    logic [9:0] opcode_in  = 10'h000;
    logic       valid_in   = 1'b0;
    logic [3:0] addr_in    = 4'h0;
    logic [7:0] wdata_in   = 8'h00;
    logic       wr_in      = 1'b0;
    logic       rd_in      = 1'b0;
    logic [7:0] rdata_out;
    logic [3:0] acc_out;
    logic [7:0] cmp_out;
    logic       done_out, skip_out, carry_out, rd_prev = 1'b0;
    prdec_note_t notes[$];
    prdec_note_t nt;
    int n_mismatch = 0;
    int cmp_count  = 0;
    logic [15:0] seed = 16'hCE10;
    logic [3:0] src[3];
    logic [3:0] a, b, cy;
    logic [7:0] cmp;
    logic [9:0] ops[3] = '{prdec_pkg::OP_COPY_IRQ, prdec_pkg::OP_COPY_SER,
                           prdec_pkg::OP_COPY_WAKE0};

    prdec_top prdec_top_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .opcode_in(opcode_in), .opcode_valid_in(valid_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .done_out(done_out),
        .skip_out(skip_out), .acc_out(acc_out), .cmp_out(cmp_out),
        .carry_out(carry_out));

    initial forever #5 ref_clk_in = ~ref_clk_in;

    // fixed-seed lfsr so every run drives the same values
    function automatic logic [3:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[3:0];
    endfunction

    // oldest note, or an all-ones note when none is waiting
    function automatic prdec_note_t take(string nm);
        if (notes.size() > 0)
            return notes.pop_front();
        return '{nm, 12'hFFF};
    endfunction

    task automatic check(string nm, logic [11:0] ex, logic [11:0] sn);
        cmp_count++;
        if (sn !== ex)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, ex, sn);
        end
    endtask

    task automatic wr(logic [3:0] ad, logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in  <= ad;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge ref_clk_in);
        wr_in    <= 1'b0;
    endtask

    // the note goes in when the strobe is raised, result checked later
    task automatic rd(logic [3:0] ad, logic [7:0] ex);
        @(posedge ref_clk_in);
        addr_in <= ad;
        rd_in   <= 1'b1;
        notes.push_back('{"rdata", {4'h0, ex}});
        @(posedge ref_clk_in);
        rd_in   <= 1'b0;
    endtask

    task automatic ins(logic [9:0] op, logic [11:0] ex, bit note);
        @(posedge ref_clk_in);
        opcode_in <= op;
        valid_in  <= 1'b1;
        if (note)
            notes.push_back('{"cmp_acc", ex});
        @(posedge ref_clk_in);
        valid_in  <= 1'b0;
    endtask

    // two words back to back, valid stays high across both
    task automatic ins2(logic [9:0] op0, logic [11:0] ex0,
                        logic [9:0] op1, logic [11:0] ex1);
        @(posedge ref_clk_in);
        opcode_in <= op0;
        valid_in  <= 1'b1;
        notes.push_back('{"cmp_acc", ex0});
        @(posedge ref_clk_in);
        opcode_in <= op1;
        notes.push_back('{"cmp_acc", ex1});
        @(posedge ref_clk_in);
        valid_in  <= 1'b0;
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watcher: a result shows one cycle after its request, oldest note first
    always @(negedge ref_clk_in)
    begin
        if (skip_out !== 1'b0)
            check("skip", 12'h000, {11'h000, skip_out});
        if (rd_prev)
        begin
            nt = take("none");
            check(nt.nm, nt.ex, {4'h0, rdata_out});
        end
        else if (rdata_out !== 8'h00)
            check("rdata_idle", 12'h000, {4'h0, rdata_out});
        if (done_out === 1'b1)
        begin
            nt = take("done");
            check(nt.nm, nt.ex, {cmp_out, acc_out});
            check("carry", {11'h000, cy[0]}, 12'(carry_out));
        end
        rd_prev = rd_in;
    end

    initial
    begin
        #200000;
        n_mismatch++;
        test_done();
    end

    initial
    begin
        repeat (6) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        // all registers clear, unmapped offset reads zero
        for (int o = 0; o < 10; o++)
            rd(4'(o), 8'h00);
        cmp = 8'h00;
        for (int r = 0; r < 3; r++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                src[k] = rnd();
                wr(4'(k + 1), {4'h0, src[k]});
            end
            a = rnd();
            b = rnd();
            wr(prdec_pkg::OFS_ACC, {4'h0, a});
            wr(prdec_pkg::OFS_BREG, {4'h0, b});
            cy = rnd();
            wr(prdec_pkg::OFS_CARRY, {7'h00, cy[0]});
            wr(4'h9, 8'hFF); // write to unmapped offset must vanish
            // back to back copies, the second overwrites the first
            ins2(ops[0], {cmp, src[0]}, ops[1], {cmp, src[1]});
            // each copy overwrites all of the accumulator
            for (int k = 0; k < 3; k++)
            begin
                ins(ops[k], {cmp, src[k]}, 1);
                a = src[k];
            end
            for (int k = 0; k < 3; k++)
                rd(4'(k + 1), {4'h0, src[k]});
            ins(prdec_pkg::OP_LOAD_CMP, {cmp, a}, 1);
            rd(prdec_pkg::OFS_BREG, {4'h0, b});
            wr(prdec_pkg::OFS_MODE, 8'h01);
            cmp = {b, a};
            ins(prdec_pkg::OP_LOAD_CMP, {cmp, a}, 1);
            rd(prdec_pkg::OFS_LAST, 8'(prdec_pkg::KIND_LOAD_CMP));
            rd(prdec_pkg::OFS_CARRY, {7'h00, cy[0]});
            wr(prdec_pkg::OFS_MODE, 8'h00);
            ins(10'h000, 12'h000, 0); // unknown opcode, no done expected
            rd(prdec_pkg::OFS_ACC, {4'h0, a});
            rd(4'h9, 8'h00);
        end
        repeat (3) @(posedge ref_clk_in);
        check("queue", 12'h000, 12'(notes.size()));
        test_done();
    end
endmodule
